//--- hw/sebf_pkg.sv
package sebf_pkg;
  // ==========================================================
  // frame and address constants
  localparam int          SEBF_BITS      = 8;
  localparam logic [2:0]  SEBF_BIT_LAST  = 3'h7;
  localparam logic [3:0]  SEBF_DEV_TYPE  = 4'ha;
  localparam int          SEBF_PAGES     = 512;
  localparam int          SEBF_PAGE_SZ   = 128;
  localparam int          SEBF_ADDR_W    = 16;
  localparam int          SEBF_DEPTH     = SEBF_PAGES * SEBF_PAGE_SZ;
  localparam logic [6:0]  SEBF_PAGE_MASK = 7'h7f;
  // ==========================================================
  // write cycle time
  localparam int          SEBF_TWR_MS    = 3;
  localparam int          SEBF_CLK_MHZ   = 100;
  localparam int          SEBF_TWR_CYC   = SEBF_TWR_MS * 1000 * SEBF_CLK_MHZ;

  // sampled bus pins
  typedef struct packed {
    logic scl;
    logic sda;
  } sebf_bus_t;

  // protocol states, one-hot
  typedef enum logic [6:0] {
    SEBF_IDLE  = 7'h01,
    SEBF_DEV   = 7'h02,
    SEBF_ADRH  = 7'h04,
    SEBF_ADRL  = 7'h08,
    SEBF_WDAT  = 7'h10,
    SEBF_RDAT  = 7'h20,
    SEBF_RACK  = 7'h40
  } sebf_state_t;
endpackage

//--- hw/sebf_frontend.sv
// Summary of operation
// - sda open drain: pull low or release
// - sample on scl rise, drive on fall
// - write guard sampled per data byte; high blocks that byte's array write
// - 512 pages of 128 bytes, 16-bit address
// - sda change with scl high is start/stop
// - start detected in any state outside the write cycle
// - stop ends current transfer
// - 8-bit words msb first, ninth-clock ack
// - standby at reset, after stop with no write queued, else at write cycle end
// - address word 1010, select bits, r/w
// - select bits compared to select pins
// - address lsb high read, low write
// - match acks, mismatch returns to standby
// - busy write cycle ignores inputs, no ack
`timescale 1ns/1ns
module sebf_frontend
  import sebf_pkg::*;
#(
  parameter int TWR_CYC = SEBF_TWR_CYC
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic chip_select_bit2,
  input  wire logic chip_select_bit1,
  input  wire logic chip_select_bit0,
  input  wire logic write_guard,
  output logic      standby,
  output logic      write_busy
);

  // ==========================================================
  // pin sampling and edge detection
  sebf_bus_t bus_r, bus_nxt;
  logic      scl_rise, scl_fall, start_ev, stop_ev;

  always_comb begin
    bus_nxt.scl = scl_in;
    bus_nxt.sda = sda_in;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bus_r <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      bus_r <= bus_nxt;
    end
  end

  // edges of the bus lines, one cycle pulses
  assign scl_rise = scl_in & ~bus_r.scl;
  assign scl_fall = ~scl_in & bus_r.scl;
  assign start_ev = scl_in & bus_r.scl & bus_r.sda & ~sda_in;
  assign stop_ev  = scl_in & bus_r.scl & ~bus_r.sda & sda_in;

  // ==========================================================
  // storage array
  logic [7:0]             mem [SEBF_DEPTH];
  logic [SEBF_ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0]             page_buf [SEBF_PAGE_SZ];
  logic [SEBF_PAGE_SZ-1:0] page_vld_r, page_vld_nxt;

  // ==========================================================
  // protocol state
  sebf_state_t state_r, state_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [7:0]  shf_r, shf_nxt;
  logic        ack_ph_r, ack_ph_nxt;    // ninth clock in progress
  logic        ack_go_r, ack_go_nxt;    // ack owed for this word
  logic        sda_low_r, sda_low_nxt;
  logic        wr_pend_r, wr_pend_nxt;
  logic [31:0] busy_cnt_r, busy_cnt_nxt;
  logic        commit;
  logic        addr_match;
  logic [2:0]  cs_pins;

  assign cs_pins    = {chip_select_bit2, chip_select_bit1,
                       chip_select_bit0};
  // device word match on type and select bits
  assign addr_match = (shf_r[7:4] == SEBF_DEV_TYPE) &&
                      (shf_r[3:1] == cs_pins);
  assign write_busy = (busy_cnt_r != 32'h0);
  assign standby    = (state_r == SEBF_IDLE) && !write_busy;
  assign commit     = stop_ev && wr_pend_r && !write_busy;

  always_comb begin
    state_nxt    = state_r;
    bit_nxt      = bit_r;
    shf_nxt      = shf_r;
    ack_ph_nxt   = ack_ph_r;
    ack_go_nxt   = ack_go_r;
    sda_low_nxt  = sda_low_r;
    addr_nxt     = addr_r;
    wr_pend_nxt  = wr_pend_r;
    page_vld_nxt = page_vld_r;
    busy_cnt_nxt = busy_cnt_r;
    if (write_busy) begin
      busy_cnt_nxt = busy_cnt_r - 32'h1;
    end
    if (write_busy) begin
      // inputs ignored during the write cycle
      state_nxt   = SEBF_IDLE;
      sda_low_nxt = 1'b0;
    end else if (start_ev) begin
      state_nxt   = SEBF_DEV;
      bit_nxt     = 3'h0;
      ack_ph_nxt  = 1'b0;
      ack_go_nxt  = 1'b0;
      sda_low_nxt = 1'b0;
    end else if (stop_ev) begin
      state_nxt   = SEBF_IDLE;
      sda_low_nxt = 1'b0;
      if (wr_pend_r) begin
        busy_cnt_nxt = 32'(TWR_CYC);
        wr_pend_nxt  = 1'b0;
        page_vld_nxt = '0;
      end
    end else if (state_r != SEBF_IDLE) begin
      if (scl_rise) begin
        if (ack_ph_r) begin
          // master ack after a read byte
          if (state_r == SEBF_RACK && sda_in) begin
            state_nxt = SEBF_IDLE;
          end
        end else begin
          bit_nxt = bit_r + 3'h1;
          // outgoing read byte stays put while it is sent
          if (state_r != SEBF_RDAT) begin
            shf_nxt    = {shf_r[6:0], sda_in};
            ack_go_nxt = (bit_r == SEBF_BIT_LAST);
          end
        end
      end else if (scl_fall) begin
        if (ack_ph_r) begin
          ack_ph_nxt  = 1'b0;
          sda_low_nxt = 1'b0;
          if (state_r == SEBF_RACK) begin
            state_nxt   = SEBF_RDAT;
            shf_nxt     = mem[addr_r];
            sda_low_nxt = ~mem[addr_r][7];
          end
        end else if (state_r == SEBF_RDAT) begin
          if (bit_r == 3'h0) begin
            ack_ph_nxt  = 1'b1;
            sda_low_nxt = 1'b0;
            state_nxt   = SEBF_RACK;
            addr_nxt    = addr_r + 16'h1;
          end else begin
            sda_low_nxt = ~shf_r[~bit_r];
          end
        end else if (ack_go_r) begin
          // eighth bit done: decide the ninth clock
          ack_go_nxt  = 1'b0;
          ack_ph_nxt  = 1'b1;
          sda_low_nxt = 1'b1;
          case (state_r)
            SEBF_DEV: begin
              if (!addr_match) begin
                state_nxt   = SEBF_IDLE;
                sda_low_nxt = 1'b0;
                ack_ph_nxt  = 1'b0;
              end else if (shf_r[0]) begin
                state_nxt = SEBF_RACK;
              end else begin
                state_nxt = SEBF_ADRH;
              end
            end
            SEBF_ADRH: begin
              addr_nxt[15:8] = shf_r;
              state_nxt      = SEBF_ADRL;
            end
            SEBF_ADRL: begin
              addr_nxt[7:0] = shf_r;
              state_nxt     = SEBF_WDAT;
            end
            SEBF_WDAT: begin
              // page roll-over within lower seven bits
              page_vld_nxt[addr_r[6:0]] = ~write_guard;
              wr_pend_nxt = wr_pend_r | ~write_guard;
              addr_nxt[6:0] = (addr_r[6:0] + 7'h1) & SEBF_PAGE_MASK;
            end
            default: begin
              state_nxt = SEBF_IDLE;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_r    <= SEBF_IDLE;
      bit_r      <= 3'h0;
      shf_r      <= 8'h0;
      ack_ph_r   <= 1'b0;
      ack_go_r   <= 1'b0;
      sda_low_r  <= 1'b0;
      addr_r     <= 16'h0;
      wr_pend_r  <= 1'b0;
      page_vld_r <= '0;
      busy_cnt_r <= 32'h0;
    end else begin
      state_r    <= state_nxt;
      bit_r      <= bit_nxt;
      shf_r      <= shf_nxt;
      ack_ph_r   <= ack_ph_nxt;
      ack_go_r   <= ack_go_nxt;
      sda_low_r  <= sda_low_nxt;
      addr_r     <= addr_nxt;
      wr_pend_r  <= wr_pend_nxt;
      page_vld_r <= page_vld_nxt;
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  // page buffer capture and array commit at stop
  always_ff @(posedge clk_sys) begin
    if (scl_fall && state_r == SEBF_WDAT && !ack_ph_r &&
        ack_go_r && !write_busy && !start_ev && !stop_ev) begin
      page_buf[addr_r[6:0]] <= shf_r;
    end
    if (commit) begin
      for (int i = 0; i < SEBF_PAGE_SZ; i++) begin
        if (page_vld_r[i]) begin
          mem[{addr_r[15:7], 7'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = sda_low_r;

  // ==========================================================
  // assertions
  sequence s_stop;
    scl_in && $past(scl_in) && !$past(sda_in) && sda_in;
  endsequence

  // a full word has just ended on an scl fall
  sequence s_word_in;
    scl_fall && ack_go_r && !write_busy && !start_ev && !stop_ev;
  endsequence

  sda_drive_low_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n) sda_oe |-> !sda_out)
    else $error("sda driven high");
  sda_edge_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    $changed(sda_oe) && reset_n && $past(reset_n) |-> $past(scl_fall))
    else $error("sda changed off scl fall");
  guard_block_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n) write_guard && !wr_pend_r |=> !wr_pend_r
      || !$past(write_guard))
    else $error("write queued while guarded");
  stop_idle_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n) s_stop |=> state_r == SEBF_IDLE)
    else $error("stop not ending transfer");
  start_dev_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n) start_ev && !write_busy |=> state_r == SEBF_DEV)
    else $error("start missed");
  busy_quiet_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n) write_busy |=> !sda_oe)
    else $error("ack during write cycle");
  miss_release_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_r == SEBF_DEV && scl_fall && ack_go_r && !ack_ph_r &&
    !addr_match && !start_ev && !stop_ev && !write_busy
    |=> state_r == SEBF_IDLE && !sda_oe)
    else $error("mismatch acknowledged");
  idle_release_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n) state_r == SEBF_IDLE |-> !sda_oe)
    else $error("sda held in standby");
  standby_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    s_stop and (!wr_pend_r && !write_busy) |=> standby)
    else $error("no standby after stop");
  busy_start_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    s_stop and (wr_pend_r && !write_busy) |=> write_busy)
    else $error("no write cycle after stop");
  dev_ack_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    s_word_in and (state_r == SEBF_DEV && addr_match) |=> sda_oe)
    else $error("matching device word not acked");
  word_ack_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    s_word_in and (state_r == SEBF_ADRH || state_r == SEBF_ADRL ||
                   state_r == SEBF_WDAT)
    |=> sda_oe && ack_ph_r)
    else $error("received word not acked");
  page_wrap_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    s_word_in and (state_r == SEBF_WDAT)
    |=> addr_r[15:7] == $past(addr_r[15:7]))
    else $error("write left its page");
endmodule

//--- tb/sebf_master_model.sv
`timescale 1ns/1ns
// ========================================
// bus master model, open drain on sda
module sebf_master_model (
  input  wire logic clk_sys,
  output logic      scl,
  output logic      m_oe,
  input  wire logic sda
);
  localparam int H = 4;
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  // one third of an scl bit period (low lasts two, high one), moves only at falling clk
  task automatic hold();
    repeat (H) @(negedge clk_sys);
  endtask
  // sda falls while scl high
  task automatic start();
    m_oe = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    m_oe = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask
  // sda rises while scl high
  task automatic stop();
    m_oe = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    m_oe = 1'b0;
    hold();
  endtask
  // data set while scl low, read back while high
  task automatic xbit(input logic b, output logic r);
    m_oe = ~b;
    hold();
    scl = 1'b1;
    hold();
    r = sda;
    scl = 1'b0;
    hold();
  endtask
  // eight bits msb first plus ninth clock
  task automatic xbyte(input logic [7:0] d, input logic a9,
                       output logic [7:0] q, output logic r9);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(a9, r9);
  endtask
  // clock until sda seen high, then start and stop
  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) begin
      xbit(1'b1, r);
      if (r === 1'b1) break;
    end
    start();
    stop();
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
// ========================================
// self-checking bench for the serial front end
module tb_top;
  import sebf_pkg::*;
  localparam int TW = 400;
  logic       clk_sys;
  logic       reset_n;
  logic       scl;
  logic       m_oe;
  logic       sda_out;
  logic       sda_oe;
  logic       standby;
  logic       write_busy;
  logic       wg;
  logic [2:0] cs;
  logic       ack;
  logic [7:0] q;
  int         n_fail;
  int         checked;
  int         cyc;
  wire        sda;
  // pull-up: low only while a party drives
  assign sda = !(m_oe || (sda_oe && !sda_out));
  sebf_master_model MST (.clk_sys(clk_sys), .scl(scl), .m_oe(m_oe),
                         .sda(sda));
  sebf_frontend #(.TWR_CYC(TW)) DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit2(cs[2]),
    .chip_select_bit1(cs[1]), .chip_select_bit0(cs[0]),
    .write_guard(wg), .standby(standby), .write_busy(write_busy));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  function automatic logic [7:0] dw(logic [2:0] c, logic rw);
    return {SEBF_DEV_TYPE, c, rw};
  endfunction
  // send a byte and expect an ack
  task automatic wb(logic [7:0] d, string what);
    MST.xbyte(d, 1'b1, q, ack);
    chk(what, 8'h00, {7'h0, ack});
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    MST.start();
    wb(dw(cs, 1'b0), "write dev ack");
    wb(a[15:8], "addr hi ack");
    wb(a[7:0], "addr lo ack");
    wb(d, "data ack");
    MST.stop();
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] exp);
    MST.start();
    wb(dw(cs, 1'b0), "dummy dev ack");
    wb(a[15:8], "addr hi ack");
    wb(a[7:0], "addr lo ack");
    MST.start();
    wb(dw(cs, 1'b1), "read dev ack");
    MST.xbyte(8'hff, 1'b1, q, ack);
    chk("read data", exp, q);
    MST.stop();
  endtask
  task automatic t_reset();
    chk("standby", 8'h01, {7'h0, standby});
    chk("oe idle", 8'h00, {7'h0, sda_oe});
    MST.recover();
    chk("sda idle", 8'h01, {7'h0, sda});
    $display("test reset done");
  endtask
  task automatic t_busy();
    wr(16'h1234, 8'ha5);
    chk("busy", 8'h01, {7'h0, write_busy});
    chk("standby busy", 8'h00, {7'h0, standby});
    MST.start();
    MST.xbyte(dw(cs, 1'b0), 1'b1, q, ack);
    chk("poll ack", 8'h01, {7'h0, ack});
    MST.stop();
    repeat (TW) @(negedge clk_sys);
    chk("busy end", 8'h00, {7'h0, write_busy});
    chk("standby end", 8'h01, {7'h0, standby});
    $display("test busy done");
  endtask
  task automatic t_edge();
    wr(16'hffff, 8'h3c);
    repeat (TW) @(negedge clk_sys);
    rd(16'hffff, 8'h3c);
    rd(16'h1234, 8'ha5);
    $display("test boundary done");
  endtask
  task automatic t_miss();
    for (int i = 0; i < 3; i++) begin
      MST.start();
      MST.xbyte(dw(cs ^ (3'h1 << i), 1'b0), 1'b1, q, ack);
      chk("select nack", 8'h01, {7'h0, ack});
      chk("oe after nack", 8'h00, {7'h0, sda_oe});
      MST.stop();
    end
    MST.start();
    MST.xbyte({4'hb, cs, 1'b0}, 1'b1, q, ack);
    chk("type nack", 8'h01, {7'h0, ack});
    MST.stop();
    chk("standby miss", 8'h01, {7'h0, standby});
    $display("test mismatch done");
  endtask
  task automatic t_guard();
    wg = 1'b1;
    wr(16'h1234, 8'h5a);
    repeat (TW) @(negedge clk_sys);
    wg = 1'b0;
    rd(16'h1234, 8'ha5);
    $display("test guard done");
  endtask
  // page write across the page end, then sequential read
  task automatic t_seq();
    MST.start();
    wb(dw(cs, 1'b0), "page dev ack");
    wb(8'h12, "page hi ack");
    wb(8'hfe, "page lo ack");
    wb(8'h11, "page d0 ack");
    wb(8'h22, "page d1 ack");
    wb(8'h33, "page d2 ack");
    MST.stop();
    repeat (TW) @(negedge clk_sys);
    MST.start();
    wb(dw(cs, 1'b0), "seq dev ack");
    wb(8'h12, "seq hi ack");
    wb(8'hfe, "seq lo ack");
    MST.start();
    wb(dw(cs, 1'b1), "seq rd ack");
    MST.xbyte(8'hff, 1'b0, q, ack);
    chk("seq data 0", 8'h11, q);
    MST.xbyte(8'hff, 1'b1, q, ack);
    chk("seq data 1", 8'h22, q);
    MST.stop();
    rd(16'h1280, 8'h33);
    $display("test page done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    n_fail = 0;
    checked = 0;
    cyc = 0;
    reset_n = 1'b0;
    wg = 1'b0;
    cs = 3'h5;
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_busy();
    t_edge();
    t_miss();
    t_guard();
    t_seq();
    summarize();
  end
endmodule
